// file: adsq_fifo.sv
`default_nettype none
module adsq_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16,
   parameter int PTR_W = 4
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic clear_i,
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o,
   output logic [PTR_W-1:0] fill_o,
   output logic full_o,
   output logic empty_o
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr_ff;
   logic [PTR_W-1:0] rd_ptr_ff;
   logic [PTR_W:0] count_ff;
   logic [PTR_W:0] nxt_count;
   logic full_ff;
   logic empty_ff;
   logic push;
   logic pop;

   // full refuses pushes until a pop or clear
   assign in_ready_o = !full_ff;
   assign out_valid_o = !empty_ff;
   assign push = in_valid_i && !full_ff;
   // a clear in the same cycle swallows the pop but keeps the push
   assign pop = out_ready_i && !empty_ff && !clear_i;
   assign out_data_o = mem[rd_ptr_ff];
   // count of 16 wraps to 0 in the pointer field
   assign fill_o = count_ff[PTR_W-1:0];
   assign full_o = full_ff;
   assign empty_o = empty_ff;

   always_comb
   begin
      if (clear_i)
      begin
         nxt_count = (PTR_W+1)'(push);
      end
      else
      begin
         nxt_count = count_ff + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         mem[clear_i ? '0 : wr_ptr_ff] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
         full_ff <= 1'b0;
         empty_ff <= 1'b1;
      end
      else
      begin
         wr_ptr_ff <= (clear_i ? '0 : wr_ptr_ff) + PTR_W'(push);
         rd_ptr_ff <= clear_i ? '0 : rd_ptr_ff + PTR_W'(pop);
         count_ff <= nxt_count;
         full_ff <= (nxt_count == (PTR_W+1)'(DEPTH));
         empty_ff <= (nxt_count == '0);
      end
   end
endmodule : adsq_fifo
`default_nettype wire

// file: adsq_map.svh
`ifndef ADSQ_MAP_SVH
`define ADSQ_MAP_SVH
// ==========================================================
// register addresses on the internal cpu bus
`define ADSQ_ADDR_STATUS 16'hffcb
`define ADSQ_ADDR_MODE 16'hffcc
`define ADSQ_ADDR_LATCH 16'hffcd
`define ADSQ_ADDR_FIFO_LO 16'hffce
`define ADSQ_ADDR_FIFO_HI 16'hffcf
// ==========================================================
// mode register fields
`define ADSQ_MODE_START_BIT 0
`define ADSQ_MODE_RPT_BIT 1
`define ADSQ_MODE_SPEED_BIT 2
`define ADSQ_MODE_CH_BIT 4
`define ADSQ_MODE_BUSY_BIT 7
// ==========================================================
// status register fields
`define ADSQ_STAT_CLR_BIT 4
`define ADSQ_STAT_EMPTY_BIT 5
`define ADSQ_STAT_FULL_BIT 6
// ==========================================================
// reset and fixed values
`define ADSQ_BIT_RST 1'b0
`define ADSQ_BYTE_RST 8'h00
`define ADSQ_EMPTY_READ 8'hff
// ==========================================================
// timing, in states and clock periods
`define ADSQ_CLK_NS 10
`define ADSQ_STATE_NS 10
`define ADSQ_STATE_CYC (`ADSQ_STATE_NS / `ADSQ_CLK_NS)
`define ADSQ_SMP_HS_STATES 2
`define ADSQ_SMP_LS_STATES 4
`define ADSQ_RESULT_STATE 5
`define ADSQ_FIFO_DEPTH 16
`define ADSQ_DATA_W 8
`endif

// file: adsq_pkg.sv
`default_nettype none
package adsq_pkg;
   // ==========================================================
   // carriers
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } adsq_bus_req_t;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } adsq_sample_t;

   // ==========================================================
   // sequencer states
   typedef enum logic [1:0] {
      ADSQ_IDLE = 2'b01,
      ADSQ_REPEAT = 2'b10
   } adsq_seq_t;
endpackage : adsq_pkg
`default_nettype wire

// file: adsq_soft_model.sv
`default_nettype none
module adsq_soft_model (
   input wire logic clk_i,
   output logic [7:0] code_zero_o,
   output logic [7:0] code_one_o,
   output logic start_pin_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      code_zero_o = 8'h3c;
      code_one_o = 8'hc5;
      start_pin_o = 1'b0;
   end
   // held four states, above the pin's minimum high width
   task automatic pulse_start();
      @(negedge clk_i);
      start_pin_o = 1'b1;
      repeat (4) @(negedge clk_i);
      start_pin_o = 1'b0;
   endtask : pulse_start
endmodule : adsq_soft_model
`default_nettype wire

// file: adsq_sync.sv
`default_nettype none
module adsq_sync (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic pin_i,
   output logic level_o,
   output logic rise_o
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   logic level_ff;
   logic rise_ff;

   // ==========================================================
   // three stages, change accepted once the last two agree
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
      end
      else
      begin
         s1_ff <= pin_i;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         level_ff <= 1'b0;
         rise_ff <= 1'b0;
      end
      else
      begin
         if (s2_ff == s3_ff)
         begin
            level_ff <= s3_ff;
         end
         rise_ff <= (s2_ff == s3_ff) && s3_ff && !level_ff;
      end
   end

   assign level_o = level_ff;
   assign rise_o = rise_ff;
endmodule : adsq_sync
`default_nettype wire

// file: adsq_top.sv
`include "adsq_map.svh"
`default_nettype none
// What this block does
// - writing start begins conversion; reads zero
// - repeat mode restarts at the end of each sampling interval
// - repeat only from software start plus repeat
// - clearing repeat stops after current conversion
// - reset clears repeat: single conversion mode
// - sampling interval two states fast, four slow
// - speed resets low; one selects high speed
// - channel bit selects input zero or one
// - every result to latch, fifo while not full
// - clear empties fifo, pointer, full; sets empty unless a result arrives in the same cycle while not full
// - sixteenth entry sets full, stops pushes
// - latch keeps updating while fifo is full
// - reset sets empty; push clears it
// - interrupt equals inverse of empty flag
// - level interrupt; only clear or draining ends
// - read while empty gives ff, no change
// - four bit pointer counts entries, zero full/empty
// - pointer stays zero on refused read/push
// - fifo readable at both port addresses
// - pin start makes one conversion, ignores repeat
// - result ready in fifth state after start
module adsq_top (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire adsq_pkg::adsq_bus_req_t bus_req_i,
   output logic [7:0] bus_rdata_o,
   input wire logic ext_start_i,
   input wire logic ext_start_en_i,
   input wire logic [7:0] analog_input_zero_code_i,
   input wire logic [7:0] analog_input_one_code_i,
   output logic input_channel_select_o,
   output logic converter_irq_o,
   output logic busy_o
);
   import adsq_pkg::*;

   localparam int PIPE = `ADSQ_RESULT_STATE - 1;
   localparam int HS_CYC = `ADSQ_SMP_HS_STATES * `ADSQ_STATE_CYC;
   localparam int LS_CYC = `ADSQ_SMP_LS_STATES * `ADSQ_STATE_CYC;
   localparam logic [2:0] HS_GAP = 3'(HS_CYC - 1);
   localparam logic [2:0] LS_GAP = 3'(LS_CYC - 1);

   // ==========================================================
   // bus decode
   logic wr_mode;
   logic wr_status;
   logic rd_fifo;
   logic hit_status;
   logic hit_mode;
   logic hit_latch;

   assign hit_status = (bus_req_i.addr == `ADSQ_ADDR_STATUS);
   assign hit_mode = (bus_req_i.addr == `ADSQ_ADDR_MODE);
   assign hit_latch = (bus_req_i.addr == `ADSQ_ADDR_LATCH);
   assign wr_mode = bus_req_i.wr && hit_mode;
   assign wr_status = bus_req_i.wr && hit_status;
   // both addresses pop, so a word load takes two entries
   assign rd_fifo = bus_req_i.rd && ((bus_req_i.addr == `ADSQ_ADDR_FIFO_LO) ||
                                    (bus_req_i.addr == `ADSQ_ADDR_FIFO_HI));

   // ==========================================================
   // mode register
   logic rpt_ff;
   logic speed_ff;
   logic ch_ff;

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rpt_ff <= `ADSQ_BIT_RST;
      end
      else if (wr_mode)
      begin
         rpt_ff <= bus_req_i.wdata[`ADSQ_MODE_RPT_BIT];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         speed_ff <= `ADSQ_BIT_RST;
      end
      else if (wr_mode)
      begin
         speed_ff <= bus_req_i.wdata[`ADSQ_MODE_SPEED_BIT];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ch_ff <= `ADSQ_BIT_RST;
      end
      else if (wr_mode)
      begin
         ch_ff <= bus_req_i.wdata[`ADSQ_MODE_CH_BIT];
      end
   end

   // the unselected pin stays with the port logic outside
   assign input_channel_select_o = ch_ff;

   // ==========================================================
   // start sources
   logic ext_level;
   logic ext_rise;
   logic sw_start;
   logic sw_repeat;
   logic ext_start;

   adsq_sync u_start_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .pin_i(ext_start_i),
      .level_o(ext_level),
      .rise_o(ext_rise)
   );

   assign sw_start = wr_mode && bus_req_i.wdata[`ADSQ_MODE_START_BIT];
   assign sw_repeat = sw_start && bus_req_i.wdata[`ADSQ_MODE_RPT_BIT];
   // one rising edge, one conversion; repeat bit not consulted
   assign ext_start = ext_rise && ext_level && ext_start_en_i;

   // ==========================================================
   // conversion sequencer
   adsq_seq_t state_ff;
   adsq_seq_t nxt_state;
   logic [2:0] gap_ff;
   logic gap_zero;
   logic take_sample;
   logic [2:0] gap_load;

   assign gap_zero = (gap_ff == 3'h0);
   assign gap_load = speed_ff ? HS_GAP : LS_GAP;

   // channel must already be set; a start in the same write
   // still samples the old selection
   always_comb
   begin
      nxt_state = state_ff;
      take_sample = 1'b0;
      unique case (state_ff)
         ADSQ_IDLE:
         begin
            if (gap_zero && (sw_start || ext_start))
            begin
               take_sample = 1'b1;
               if (sw_repeat)
               begin
                  nxt_state = ADSQ_REPEAT;
               end
            end
         end
         ADSQ_REPEAT:
         begin
            if (gap_zero)
            begin
               if (rpt_ff)
               begin
                  take_sample = 1'b1;
               end
               else
               begin
                  nxt_state = ADSQ_IDLE;
               end
            end
         end
         default:
         begin
            nxt_state = ADSQ_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_ff <= ADSQ_IDLE;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   // spacing between samples; a start during it is dropped
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         gap_ff <= 3'h0;
      end
      else if (take_sample)
      begin
         gap_ff <= gap_load;
      end
      else if (!gap_zero)
      begin
         gap_ff <= gap_ff - 3'h1;
      end
   end

   // ==========================================================
   // conversion pipeline: sample in state 1, result in state 5
   adsq_sample_t pipe_ff [PIPE];
   logic [PIPE-1:0] pipe_valid;
   adsq_sample_t sample_in;
   adsq_sample_t result;

   always_comb
   begin
      sample_in.valid = take_sample;
      sample_in.data = ch_ff ? analog_input_one_code_i : analog_input_zero_code_i;
   end

   generate
      for (genvar i = 0; i < PIPE; i++)
      begin : g_stage
         always_ff @(posedge clk_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               pipe_ff[i] <= '0;
            end
            else if (i == 0)
            begin
               pipe_ff[i] <= sample_in;
            end
            else
            begin
               pipe_ff[i] <= pipe_ff[(i == 0) ? 0 : i-1];
            end
         end
         assign pipe_valid[i] = pipe_ff[i].valid;
      end
   endgenerate

   assign result = pipe_ff[PIPE-1];

   // ==========================================================
   // result latch and fifo
   logic [7:0] latch_ff;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [7:0] fifo_data;
   logic [3:0] fifo_fill;
   logic fifo_full;
   logic fifo_empty;
   logic fifo_clear;
   logic fifo_pop;

   // latch is written regardless of fifo room
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         latch_ff <= `ADSQ_BYTE_RST;
      end
      else if (result.valid)
      begin
         latch_ff <= result.data;
      end
   end

   assign fifo_clear = wr_status && bus_req_i.wdata[`ADSQ_STAT_CLR_BIT];
   // a read while empty never reaches the fifo
   assign fifo_pop = rd_fifo && fifo_out_valid;

   // a full fifo drops the result rather than stall conversion
   adsq_fifo #(
      .WIDTH(`ADSQ_DATA_W),
      .DEPTH(`ADSQ_FIFO_DEPTH),
      .PTR_W(4)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .clear_i(fifo_clear),
      .in_valid_i(result.valid),
      .in_data_i(result.data),
      .in_ready_o(fifo_in_ready),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_pop),
      .out_data_o(fifo_data),
      .fill_o(fifo_fill),
      .full_o(fifo_full),
      .empty_o(fifo_empty)
   );

   // ==========================================================
   // interrupt: level, follows the empty flag only
   logic irq_ff;

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         irq_ff <= 1'b0;
      end
      else
      begin
         // same next-empty view as the fifo; a clear keeps
         // only a push that a non-full fifo accepts
         irq_ff <= fifo_clear ? (result.valid && fifo_in_ready) :
                   ((!fifo_empty || (result.valid && fifo_in_ready)) &&
                   !(fifo_pop && fifo_fill == 4'h1 && !result.valid &&
                     !fifo_full));
      end
   end

   assign converter_irq_o = irq_ff;

   // ==========================================================
   // busy status
   logic busy_ff;

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         busy_ff <= 1'b0;
      end
      else
      begin
         busy_ff <= (nxt_state != ADSQ_IDLE) || take_sample || (|pipe_valid[PIPE-2:0]);
      end
   end

   assign busy_o = busy_ff;

   // ==========================================================
   // read data, one cycle after the read strobe
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;

   always_comb
   begin
      nxt_rdata = `ADSQ_BYTE_RST;
      if (hit_status)
      begin
         nxt_rdata[3:0] = fifo_fill;
         nxt_rdata[`ADSQ_STAT_EMPTY_BIT] = fifo_empty;
         nxt_rdata[`ADSQ_STAT_FULL_BIT] = fifo_full;
      end
      else if (hit_mode)
      begin
         // start bit always reads back zero
         nxt_rdata[`ADSQ_MODE_START_BIT] = 1'b0;
         nxt_rdata[`ADSQ_MODE_RPT_BIT] = rpt_ff;
         nxt_rdata[`ADSQ_MODE_SPEED_BIT] = speed_ff;
         nxt_rdata[`ADSQ_MODE_CH_BIT] = ch_ff;
         nxt_rdata[`ADSQ_MODE_BUSY_BIT] = busy_ff;
      end
      else if (hit_latch)
      begin
         nxt_rdata = latch_ff;
      end
      else if (rd_fifo)
      begin
         nxt_rdata = fifo_out_valid ? fifo_data : `ADSQ_EMPTY_READ;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rdata_ff <= `ADSQ_BYTE_RST;
      end
      else if (bus_req_i.rd)
      begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign bus_rdata_o = rdata_ff;
endmodule : adsq_top
`default_nettype wire

// file: adsq_top_fix_note.sv
`default_nettype none
`default_nettype wire

// file: adsq_top_sva.sv
`include "adsq_map.svh"
`default_nettype none
module adsq_top_sva (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire adsq_pkg::adsq_bus_req_t bus_req_i,
   input wire logic [7:0] bus_rdata_o,
   input wire logic input_channel_select_o,
   input wire logic converter_irq_o,
   input wire logic busy_o
);
   import adsq_pkg::*;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   // ==========
   // decoded accesses
   logic mode_wr, clr_wr, rd_mode, rd_stat, rd_fifo;
   assign mode_wr = bus_req_i.wr && bus_req_i.addr == `ADSQ_ADDR_MODE;
   assign clr_wr = bus_req_i.wr && bus_req_i.addr == `ADSQ_ADDR_STATUS && bus_req_i.wdata[4];
   assign rd_mode = bus_req_i.rd && bus_req_i.addr == `ADSQ_ADDR_MODE;
   assign rd_stat = bus_req_i.rd && bus_req_i.addr == `ADSQ_ADDR_STATUS;
   assign rd_fifo = bus_req_i.rd && bus_req_i.addr[15:1] == 15'h7fe7;
   // ==========
   // assertions
   AST_START_RUNS: assert property (mode_wr && bus_req_i.wdata[0] && !busy_o |-> ##[1:2] busy_o)
      else $error("start write did not raise busy");
   AST_MODE_READ: assert property (rd_mode |=> (bus_rdata_o & 8'h69) == 8'h00)
      else $error("mode read shows start or spare bits");
   AST_STOP_IDLE: assert property (mode_wr && !bus_req_i.wdata[1] |-> ##[1:14] !busy_o)
      else $error("converter kept running without repeat");
   AST_CHANNEL: assert property (mode_wr |=> input_channel_select_o == $past(bus_req_i.wdata[4]))
      else $error("channel output does not follow write");
   AST_EMPTY_FF: assert property (rd_fifo && !converter_irq_o && !busy_o |=> bus_rdata_o == `ADSQ_EMPTY_READ)
      else $error("empty fifo read not ff");
   AST_PTR_ZERO: assert property (rd_stat ##1 (bus_rdata_o[5] | bus_rdata_o[6]) |-> bus_rdata_o[3:0] == 4'h0)
      else $error("pointer nonzero while empty or full");
   AST_FULL_EMPTY: assert property (rd_stat ##1 bus_rdata_o[6] |-> !bus_rdata_o[5])
      else $error("full and empty both set");
   AST_IRQ_EMPTY: assert property (rd_stat |=> bus_rdata_o[5] == !$past(converter_irq_o))
      else $error("irq not inverse of empty");
   AST_IRQ_LEVEL: assert property ($fell(converter_irq_o) |-> $past(rd_fifo) || $past(clr_wr) || $past(clr_wr, 2))
      else $error("irq dropped without pop or clear");
   AST_CLEAR: assert property (clr_wr && !busy_o |-> ##[1:2] !converter_irq_o)
      else $error("clear left irq high");
   // ==========
   // coverage
   COV_REPEAT: cover property (mode_wr && bus_req_i.wdata[1:0] == 2'b11);
   COV_IRQ: cover property ($rose(converter_irq_o));
   COV_FULL: cover property (rd_stat ##1 bus_rdata_o[6]);
endmodule : adsq_top_sva
bind adsq_top adsq_top_sva u_sva (.clk_i, .rst_n_i, .bus_req_i, .bus_rdata_o,
   .input_channel_select_o, .converter_irq_o, .busy_o);
`default_nettype wire

// file: adsq_top_tb.sv
`include "adsq_map.svh"
`default_nettype none
module adsq_top_tb;
   import adsq_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [15:0] A_ST = `ADSQ_ADDR_STATUS;
   localparam logic [15:0] A_MD = `ADSQ_ADDR_MODE;
   localparam logic [15:0] A_LT = `ADSQ_ADDR_LATCH;
   localparam logic [15:0] A_FL = `ADSQ_ADDR_FIFO_LO;
   localparam logic [15:0] A_FH = `ADSQ_ADDR_FIFO_HI;
   logic clk, rst_n, ext_start, ext_en, ch, irq, busy;
   logic [7:0] rdata, code0, code1;
   adsq_bus_req_t req;
   int n_fail = 0;
   int n_checks = 0;
   int cyc = 0;
   adsq_top uut (.clk_i(clk), .rst_n_i(rst_n), .bus_req_i(req), .bus_rdata_o(rdata),
      .ext_start_i(ext_start), .ext_start_en_i(ext_en), .analog_input_zero_code_i(code0),
      .analog_input_one_code_i(code1), .input_channel_select_o(ch),
      .converter_irq_o(irq), .busy_o(busy));
   adsq_soft_model mdl (.clk_i(clk), .code_zero_o(code0), .code_one_o(code1),
      .start_pin_o(ext_start));
   // ==========
   // bus and check helpers
   task automatic conclude();
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : conclude
   task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(negedge clk);
      req.wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(negedge clk);
      req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(negedge clk);
      req.rd = 1'b0;
      @(negedge clk);
      d = rdata;
   endtask : rd
   task automatic rchk(input string n, input logic [15:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      chk(n, d, e);
   endtask : rchk
   // busy may rise a few states late, so look only after that
   task automatic wait_idle();
      int k;
      k = 0;
      repeat (3) @(negedge clk);
      while (busy !== 1'b0 && k < 200)
      begin
         @(negedge clk);
         k++;
      end
      chk("idle", {7'h0, busy}, 8'h00);
   endtask : wait_idle
   // ==========
   // scenarios
   task automatic t_reset();
      rchk("mode", A_MD, 8'h00);
      rchk("status", A_ST, 8'h20);
      chk("irq", {7'h0, irq}, 8'h00);
      chk("channel", {7'h0, ch}, 8'h00);
   endtask : t_reset
   task automatic t_single();
      wr(A_MD, 8'h01);
      repeat (3) @(negedge clk);
      chk("early", {7'h0, irq}, 8'h00);
      @(negedge clk);
      chk("ready", {7'h0, irq}, 8'h01);
      wait_idle();
      rchk("latch", A_LT, 8'h3c);
      rchk("status", A_ST, 8'h01);
      chk("irq", {7'h0, irq}, 8'h01);
      rchk("fifo", A_FL, 8'h3c);
      chk("irq", {7'h0, irq}, 8'h00);
      rchk("empty read", A_FL, 8'hff);
      rchk("status", A_ST, 8'h20);
      wr(A_MD, 8'h10);
      chk("channel", {7'h0, ch}, 8'h01);
      wr(A_MD, 8'h11);
      wait_idle();
      rchk("mode", A_MD, 8'h10);
      rchk("latch one", A_LT, 8'hc5);
      wr(A_ST, 8'h10);
   endtask : t_single
   // slow window twice the fast one: both give eleven samples
   // speed is set before the start so every gap uses it
   task automatic t_rate();
      logic [7:0] d;
      for (int s = 0; s < 2; s++)
      begin
         wr(A_MD, s ? 8'h04 : 8'h00);
         wr(A_MD, s ? 8'h07 : 8'h03);
         repeat (s ? 18 : 38) @(negedge clk);
         wr(A_MD, s ? 8'h04 : 8'h00);
         wait_idle();
         rd(A_ST, d);
         chk("rate", d, 8'h0b);
         rchk("speed", A_MD, s ? 8'h04 : 8'h00);
         wr(A_ST, 8'h10);
      end
   endtask : t_rate
   task automatic t_full();
      int k;
      logic [7:0] d;
      k = 0;
      d = 8'h00;
      wr(A_MD, 8'h14);
      wr(A_MD, 8'h17);
      while (d[6] !== 1'b1 && k < 50)
      begin
         rd(A_ST, d);
         k++;
      end
      chk("full", d, 8'h40);
      mdl.code_one_o = 8'h5a;
      repeat (8) @(negedge clk);
      rchk("latch full", A_LT, 8'h5a);
      wr(A_MD, 8'h14);
      wait_idle();
      rchk("full held", A_ST, 8'h40);
      rchk("load low", A_FL, 8'hc5);
      rchk("load high", A_FH, 8'hc5);
      rchk("pointer", A_ST, 8'h0e);
      wr(A_ST, 8'h10);
      rchk("cleared", A_ST, 8'h20);
      chk("irq", {7'h0, irq}, 8'h00);
      mdl.code_one_o = 8'hc5;
   endtask : t_full
   task automatic t_ext();
      wr(A_MD, 8'h02);
      mdl.pulse_start();
      wait_idle();
      rchk("pin off", A_ST, 8'h20);
      ext_en = 1'b1;
      mdl.pulse_start();
      wait_idle();
      rchk("pin once", A_ST, 8'h01);
      rchk("pin data", A_FL, 8'h3c);
   endtask : t_ext
   // ==========
   // clock, reset, sequence, timeout
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      rst_n = 1'b0;
      req = '0;
      ext_en = 1'b0;
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      t_reset();
      t_single();
      t_rate();
      t_full();
      t_ext();
      conclude();
   end
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_fail++;
         conclude();
      end
   end
endmodule : adsq_top_tb
`default_nettype wire
